// file: core/cfs_pkg.sv
/*
 package for the flags and segment state block: bit positions of the
 flags register and machine control register, reset values, operation
 codes and the descriptor cache layout.
 assumes one processor clock domain.
*/
package cfs_pkg;
	// flags register bit positions
	localparam int FL_CARRY = 0;
	localparam int FL_PARITY = 2;
	localparam int FL_AUX = 4;
	localparam int FL_ZERO = 6;
	localparam int FL_SIGN = 7;
	localparam int FL_STEP = 8;
	localparam int FL_IE = 9;
	localparam int FL_DIR = 10;
	localparam int FL_OVF = 11;
	localparam int FL_IO_PRIVILEGE_LEVEL_LO = 12;
	localparam int FL_NEST = 14;
	localparam int FL_RESUME = 16;
	localparam int FL_VMODE = 17;
	// fixed bit 1 reads as one, other reserved bits zero
	localparam logic [31:0] FL_FIXED_ONE = 32'h0000_0002;
	localparam logic [31:0] FL_DEFINED = 32'h0003_7fd5;
	localparam logic [31:0] FL_RESET = 32'h0000_0002;
	// machine control register
	localparam int MC_PROT = 0;
	localparam int MC_PAGE = 31;
	localparam logic [31:0] MC_RESET = 32'h0000_0000;
	// real mode segment limit, 64 kbyte
	localparam logic [31:0] REAL_LIMIT = 32'h0000_ffff;
	localparam int SEL_SHIFT = 4;
	localparam int NSEG = 6;
	// attribute bits used by the access check
	localparam int AT_PRESENT = 7;
	localparam int AT_CODE = 3;
	localparam int AT_WR_RD = 1; // writable for data, readable for code
	localparam logic [7:0] REAL_ATTR = 8'h93; // present, data, writable

	typedef enum logic [1:0] {
		CFS_SZ8 = 2'b00,
		CFS_SZ16 = 2'b01,
		CFS_SZ32 = 2'b10
	} cfs_size_t;

	// flags register write sources
	typedef enum logic [2:0] {
		CFS_FW_NONE = 3'b000,
		CFS_FW_POP_FLAGS_OP = 3'b001,
		CFS_FW_INTERRUPT_RETURN_OP = 3'b010,
		CFS_FW_TASK = 3'b011,
		CFS_FW_DIRECT = 3'b100
	} cfs_fwr_t;

	// machine control register write sources
	typedef enum logic [1:0] {
		CFS_MW_NONE = 2'b00,
		CFS_MW_LOAD_STATUS_WORD_OP = 2'b01,
		CFS_MW_FULL = 2'b10
	} cfs_mwr_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		logic [7:0] attr;
	} cfs_desc_t;

	// arithmetic operands presented by the datapath
	typedef struct packed {
		logic valid;
		cfs_size_t size;
		logic is_sub;
		logic [31:0] a;
		logic [31:0] b;
		logic carry_in;
	} cfs_alu_t;

	typedef struct packed {
		logic valid;
		logic [2:0] seg;
		logic write;
		logic fetch;
		logic [31:0] offset;
	} cfs_mref_t;
endpackage

// file: core/cfs_core.sv
/*
 flags register, six segment selectors with hidden descriptor caches and
 the machine control register of the processor.
 assumes the sequencer reports instruction completion, flag loads and
 selector loads as one-cycle strobes, and that descriptors are fetched
 by the caller before a protected mode selector load.
*/
// Functional notes
// - virtual mode in protected mode loads segments real-style, faults privileged opcodes.
// - virtual mode bit set only by interrupt return at level 0 or task switch.
// - push of flags writes zero there; saved images show virtual mode.
// - resume flag suppresses debug faults on the next instruction.
// - resume flag cleared on clean completion unless reloaded from memory image.
// - nested task flag picks inter-task or intra-task interrupt return.
// - pop or interrupt return loads nested task flag at any level.
// - io privilege field bounds privilege allowed to do io without fault.
// - pop or return changes interrupt enable only if privilege allows, io field only at level zero.
// - overflow set when carry into sign bit differs from carry out.
// - direction flag selects index increment or decrement.
// - interrupt enable gates the maskable interrupt request pin.
// - single-step flag traps after next instruction.
// - sign flag copies result top bit for operand size.
// - zero flag set when result is zero at operand size.
// - aux carry reflects carry or borrow at bit 3 only.
// - parity set for even ones in low result byte.
// - carry flag holds carry or borrow at the top bit.
// - selector load refreshes descriptor cache, real mode base is selector times 16.
// - memory reference adds base, checks limit and attributes.
// - status-word load and store touch only the low 16 bits.
// - bit 31 of machine control enables paging.
// - protection enable set by either load, cleared only by full load.
`timescale 1ns/10ps
`default_nettype none
module cfs_core
	import cfs_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// privilege and instruction events
	input wire logic [1:0] i_cpl,
	input wire logic i_insn_done,
	input wire logic i_insn_fault,
	input wire logic i_task_vm86,
	// flags writes
	input wire cfs_pkg::cfs_fwr_t i_fl_wr,
	input wire logic [31:0] i_fl_wdata,
	input wire cfs_pkg::cfs_alu_t i_alu,
	input wire logic i_alu_upd_cf,
	// interrupts and debug
	input wire logic i_maskable_irq_pin,
	input wire logic i_debug_hit,
	// io and privileged opcodes
	input wire logic i_io_insn,
	input wire logic i_priv_insn,
	// segment loads
	input wire logic i_seg_ld,
	input wire logic [2:0] i_seg_idx,
	input wire logic [15:0] i_seg_sel,
	input wire cfs_pkg::cfs_desc_t i_seg_desc,
	// machine control register
	input wire cfs_pkg::cfs_mwr_t i_mc_wr,
	input wire logic [31:0] i_mc_wdata,
	// memory reference
	input wire cfs_pkg::cfs_mref_t i_mref,
	// flags outputs
	output logic [31:0] o_flags,
	output logic [31:0] o_flags_push,
	output logic [31:0] o_flags_saved,
	output logic [31:0] o_alu_result,
	// control decisions
	output logic o_irq_take,
	output logic o_debug_fault,
	output logic o_step_trap,
	output logic o_gp_fault,
	output logic o_io_bitmap_check,
	output logic o_interrupt_return_op_intertask,
	output logic signed [2:0] o_index_step,
	output logic o_vm86_active,
	// machine control outputs
	output logic [31:0] o_mc,
	output logic [15:0] o_status_word,
	output logic o_paging_en,
	output logic o_prot_en,
	// segment state and address
	output logic [15:0] o_sel [NSEG],
	output logic [31:0] o_linear,
	output logic o_limit_fault,
	output logic o_attr_fault
);
	logic rst_m, rst_s;
	logic [31:0] flags_r, mc_r;
	logic [15:0] sel_r [NSEG];
	cfs_desc_t cache_r [NSEG];
	logic step_arm_r;
	logic [32:0] sum;
	logic [4:0] nib;
	logic [31:0] res, img;
	logic c_top, c_into, sgn;
	logic vm_act;

	// reset release through two flip-flops
	// assertion acts at once, release waits two edges for a clean removal
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	assign vm_act = mc_r[MC_PROT] & flags_r[FL_VMODE];

	// adder with carry into and out of the sign bit
	always_comb
	begin
		logic [31:0] bb;
		bb = i_alu.is_sub ? ~i_alu.b : i_alu.b;
		sum = {1'b0, i_alu.a} + {1'b0, bb} + {32'h0, i_alu.is_sub ^ i_alu.carry_in};
		nib = {1'b0, i_alu.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, i_alu.is_sub ^ i_alu.carry_in};
		res = sum[31:0];
		case (i_alu.size)
			CFS_SZ8:
			begin
				c_top = res[8] ^ i_alu.a[8] ^ bb[8];
				c_into = res[7] ^ i_alu.a[7] ^ bb[7];
				sgn = res[7];
			end
			CFS_SZ16:
			begin
				c_top = res[16] ^ i_alu.a[16] ^ bb[16];
				c_into = res[15] ^ i_alu.a[15] ^ bb[15];
				sgn = res[15];
			end
			default:
			begin
				c_top = sum[32];
				c_into = res[31] ^ i_alu.a[31] ^ bb[31];
				sgn = res[31];
			end
		endcase
	end

	// image that a flags load would place
	// protected bits fall back to the value already held
	always_comb
	begin
		img = flags_r;
		case (i_fl_wr)
			CFS_FW_POP_FLAGS_OP, CFS_FW_INTERRUPT_RETURN_OP:
			begin
				img = (i_fl_wdata & FL_DEFINED) | FL_FIXED_ONE;
				img[FL_NEST] = i_fl_wdata[FL_NEST];
				if (i_cpl > flags_r[FL_IO_PRIVILEGE_LEVEL_LO +: 2])
					img[FL_IE] = flags_r[FL_IE];
				// io field only at level 0
				if (i_cpl != 2'b00)
					img[FL_IO_PRIVILEGE_LEVEL_LO +: 2] = flags_r[FL_IO_PRIVILEGE_LEVEL_LO +: 2];
				if (i_fl_wr == CFS_FW_POP_FLAGS_OP || i_cpl != 2'b00 || !mc_r[MC_PROT])
					img[FL_VMODE] = flags_r[FL_VMODE];
			end
			CFS_FW_TASK:
			begin
				// task switch loads all in protected mode
				img = (i_fl_wdata & FL_DEFINED) | FL_FIXED_ONE;
				if (!mc_r[MC_PROT])
					img[FL_VMODE] = flags_r[FL_VMODE];
			end
			CFS_FW_DIRECT:
			begin
				img = (i_fl_wdata & FL_DEFINED) | FL_FIXED_ONE;
				img[FL_VMODE] = flags_r[FL_VMODE];
			end
			default:
			begin
				img = flags_r;
			end
		endcase
	end

	// flags register update
	// a flags load wins over the alu update and resume clear of that cycle
	always_ff @(posedge i_clk or negedge rst_s)
	begin
		if (!rst_s)
			flags_r <= FL_RESET;
		else if (i_fl_wr != CFS_FW_NONE)
			flags_r <= img;
		else
		begin
			if (i_alu.valid)
			begin
				flags_r[FL_OVF] <= c_top ^ c_into;
				flags_r[FL_SIGN] <= sgn;
				case (i_alu.size)
					CFS_SZ8: flags_r[FL_ZERO] <= (res[7:0] == 8'h00);
					CFS_SZ16: flags_r[FL_ZERO] <= (res[15:0] == 16'h0000);
					default: flags_r[FL_ZERO] <= (res == 32'h0000_0000);
				endcase
				flags_r[FL_AUX] <= nib[4] ^ i_alu.is_sub;
				flags_r[FL_PARITY] <= ~^res[7:0];
				if (i_alu_upd_cf)
					flags_r[FL_CARRY] <= c_top ^ i_alu.is_sub;
			end
			if (i_insn_done && !i_insn_fault)
				flags_r[FL_RESUME] <= 1'b0;
		end
	end

	// single-step arms at the start of the next instruction
	// sampled at completion, so a newly loaded step flag waits one instruction
	always_ff @(posedge i_clk or negedge rst_s)
	begin
		if (!rst_s)
			step_arm_r <= 1'b0;
		else if (i_insn_done)
			step_arm_r <= flags_r[FL_STEP];
	end

	// machine control register
	// reserved and coprocessor bits are stored as written
	always_ff @(posedge i_clk or negedge rst_s)
	begin
		if (!rst_s)
			mc_r <= MC_RESET;
		else
		begin
			case (i_mc_wr)
				CFS_MW_LOAD_STATUS_WORD_OP:
				begin
					mc_r[15:1] <= i_mc_wdata[15:1];
					mc_r[MC_PROT] <= mc_r[MC_PROT] | i_mc_wdata[MC_PROT];
				end
				CFS_MW_FULL: mc_r <= i_mc_wdata;
				default: mc_r <= mc_r;
			endcase
		end
	end

	// selectors and descriptor caches
	// limit and attributes are fixed outside protected mode
	always_ff @(posedge i_clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			for (int i = 0; i < NSEG; i++)
			begin
				sel_r[i] <= 16'h0000;
				cache_r[i] <= '{base: 32'h0000_0000, limit: REAL_LIMIT, attr: REAL_ATTR};
			end
		end
		else if (i_seg_ld && i_seg_idx < 3'(NSEG))
		begin
			sel_r[i_seg_idx] <= i_seg_sel;
			// real and virtual mode take shifted base
			if (!mc_r[MC_PROT] || vm_act)
			begin
				cache_r[i_seg_idx].base <= 32'(i_seg_sel) << SEL_SHIFT;
				cache_r[i_seg_idx].limit <= REAL_LIMIT;
				cache_r[i_seg_idx].attr <= REAL_ATTR;
			end
			else
				cache_r[i_seg_idx] <= i_seg_desc;
		end
	end

	// memory reference translation and checks
	// a segment index above five reads the first cache, never an undefined one
	always_comb
	begin
		cfs_desc_t d;
		d = cache_r[(i_mref.seg < 3'(NSEG)) ? i_mref.seg : 3'h0];
		o_linear = d.base + i_mref.offset;
		o_limit_fault = i_mref.valid & (i_mref.offset > d.limit);
		o_attr_fault = i_mref.valid & (~d.attr[AT_PRESENT]
			| (i_mref.write & (d.attr[AT_CODE] | ~d.attr[AT_WR_RD]))
			| (i_mref.fetch & ~d.attr[AT_CODE])
			| (~i_mref.write & ~i_mref.fetch & d.attr[AT_CODE] & ~d.attr[AT_WR_RD]));
	end

	// control decisions from flags
	always_comb
	begin
		o_irq_take = i_maskable_irq_pin & flags_r[FL_IE];
		o_debug_fault = i_debug_hit & ~flags_r[FL_RESUME];
		o_step_trap = i_insn_done & step_arm_r;
		o_io_bitmap_check = i_io_insn & mc_r[MC_PROT] & (vm_act | (i_cpl > flags_r[FL_IO_PRIVILEGE_LEVEL_LO +: 2]));
		// privileged opcodes fault in virtual mode
		o_gp_fault = (i_priv_insn & vm_act) | (o_io_bitmap_check & ~vm_act);
		o_interrupt_return_op_intertask = flags_r[FL_NEST] & mc_r[MC_PROT];
		o_index_step = flags_r[FL_DIR] ? -3'sd1 : 3'sd1;
	end

	// register views
	always_comb
	begin
		o_flags = flags_r;
		// pushed image has zero virtual mode
		o_flags_push = flags_r & ~(32'h1 << FL_VMODE);
		o_flags_saved = flags_r | ({31'h0, i_task_vm86} << FL_VMODE);
		o_alu_result = res;
		o_vm86_active = vm_act;
		o_mc = mc_r;
		o_status_word = mc_r[15:0];
		o_paging_en = mc_r[MC_PAGE];
		o_prot_en = mc_r[MC_PROT];
		for (int i = 0; i < NSEG; i++)
			o_sel[i] = sel_r[i];
	end
endmodule // cfs_core
`default_nettype wire

// file: tb/cfs_core_sva.sv
/*
 checker for the flags and machine control ports of cfs_core.
 assumes it is bound to cfs_core and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module cfs_core_sva
	import cfs_pkg::*;
(
	// watched ports
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_cpl,
	input wire logic i_insn_done,
	input wire logic i_insn_fault,
	input wire cfs_pkg::cfs_fwr_t i_fl_wr,
	input wire logic [31:0] i_fl_wdata,
	input wire logic i_maskable_irq_pin,
	input wire cfs_pkg::cfs_mwr_t i_mc_wr,
	input wire logic [31:0] o_flags,
	input wire logic [31:0] o_flags_push,
	input wire logic o_irq_take,
	input wire logic o_debug_fault,
	input wire logic signed [2:0] o_index_step,
	input wire logic [31:0] o_mc,
	input wire logic [15:0] o_status_word,
	input wire logic o_paging_en,
	input wire logic o_prot_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// flag loads from a popped image
	sequence s_pop;
		i_fl_wr == CFS_FW_POP_FLAGS_OP;
	endsequence
	sequence s_clean_done;
		i_insn_done && !i_insn_fault && i_fl_wr == CFS_FW_NONE;
	endsequence
	AST_IRQ: assert property (o_irq_take |-> i_maskable_irq_pin && o_flags[FL_IE])
		else $error("request taken while masked");
	AST_PUSH_VM: assert property (o_flags_push[FL_VMODE] == 1'b0)
		else $error("pushed image shows virtual mode");
	AST_DIR: assert property (o_index_step == (o_flags[FL_DIR] ? -3'sd1 : 3'sd1))
		else $error("index step wrong");
	AST_RESUME: assert property (o_flags[FL_RESUME] |-> !o_debug_fault)
		else $error("debug fault while resume set");
	AST_RF_CLR: assert property (s_clean_done |=> !o_flags[FL_RESUME])
		else $error("resume flag kept");
	AST_POP_VM: assert property (s_pop |=> $stable(o_flags[FL_VMODE]))
		else $error("pop changed virtual mode");
	AST_POP_IO_PRIVILEGE_LEVEL: assert property (s_pop ##0 (i_cpl != 2'h0) |=> $stable(o_flags[13:12]))
		else $error("io field changed above level zero");
	AST_NT: assert property (i_fl_wr inside {CFS_FW_POP_FLAGS_OP, CFS_FW_INTERRUPT_RETURN_OP} |=> o_flags[FL_NEST] == $past(i_fl_wdata[FL_NEST]))
		else $error("nested task not loaded");
	AST_ALIAS: assert property (o_status_word == o_mc[15:0] && o_paging_en == o_mc[MC_PAGE] && o_prot_en == o_mc[MC_PROT])
		else $error("status outputs disagree");
	AST_LOAD_STATUS_WORD_OP: assert property (i_mc_wr == CFS_MW_LOAD_STATUS_WORD_OP |=> $stable(o_mc[31:16]) && (o_mc[0] || !$past(o_mc[0])))
		else $error("status load overreached");
endmodule // cfs_core_sva
bind cfs_core cfs_core_sva chk (
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.i_cpl(i_cpl),
	.i_insn_done(i_insn_done),
	.i_insn_fault(i_insn_fault),
	.i_fl_wr(i_fl_wr),
	.i_fl_wdata(i_fl_wdata),
	.i_maskable_irq_pin(i_maskable_irq_pin),
	.i_mc_wr(i_mc_wr),
	.o_flags(o_flags),
	.o_flags_push(o_flags_push),
	.o_irq_take(o_irq_take),
	.o_debug_fault(o_debug_fault),
	.o_index_step(o_index_step),
	.o_mc(o_mc),
	.o_status_word(o_status_word),
	.o_paging_en(o_paging_en),
	.o_prot_en(o_prot_en)
);
`default_nettype wire

// file: tb/cfs_core_tb.sv
/*
 self-checking bench for cfs_core.
 assumes cfs_pkg and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module cfs_core_tb;
	import cfs_pkg::*;
	logic i_clk = 0, i_rst_b = 0, i_insn_done = 0, i_insn_fault = 0, i_task_vm86 = 0, i_alu_upd_cf = 1;
	logic i_maskable_irq_pin = 0, i_debug_hit = 0, i_io_insn = 0, i_priv_insn = 0, i_seg_ld = 0;
	logic [1:0] i_cpl = 0;
	logic [2:0] i_seg_idx = 0;
	logic [15:0] i_seg_sel = 0;
	logic [31:0] i_fl_wdata = 0, i_mc_wdata = 0;
	cfs_fwr_t i_fl_wr = CFS_FW_NONE;
	cfs_mwr_t i_mc_wr = CFS_MW_NONE;
	cfs_alu_t i_alu = '0;
	cfs_desc_t i_seg_desc = '0;
	cfs_mref_t i_mref = '0;
	logic [31:0] o_flags, o_flags_push, o_flags_saved, o_alu_result, o_mc, o_linear;
	logic o_irq_take, o_debug_fault, o_step_trap, o_gp_fault, o_io_bitmap_check, o_interrupt_return_op_intertask, o_vm86_active;
	logic signed [2:0] o_index_step;
	logic [15:0] o_status_word;
	logic o_paging_en, o_prot_en, o_limit_fault, o_attr_fault;
	logic [15:0] o_sel [NSEG];
	int num_errors = 0, num_checks = 0, cycles = 0;
	cfs_core uut (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_cpl(i_cpl),
		.i_insn_done(i_insn_done),
		.i_insn_fault(i_insn_fault),
		.i_task_vm86(i_task_vm86),
		.i_fl_wr(i_fl_wr),
		.i_fl_wdata(i_fl_wdata),
		.i_alu(i_alu),
		.i_alu_upd_cf(i_alu_upd_cf),
		.i_maskable_irq_pin(i_maskable_irq_pin),
		.i_debug_hit(i_debug_hit),
		.i_io_insn(i_io_insn),
		.i_priv_insn(i_priv_insn),
		.i_seg_ld(i_seg_ld),
		.i_seg_idx(i_seg_idx),
		.i_seg_sel(i_seg_sel),
		.i_seg_desc(i_seg_desc),
		.i_mc_wr(i_mc_wr),
		.i_mc_wdata(i_mc_wdata),
		.i_mref(i_mref),
		.o_flags(o_flags),
		.o_flags_push(o_flags_push),
		.o_flags_saved(o_flags_saved),
		.o_alu_result(o_alu_result),
		.o_irq_take(o_irq_take),
		.o_debug_fault(o_debug_fault),
		.o_step_trap(o_step_trap),
		.o_gp_fault(o_gp_fault),
		.o_io_bitmap_check(o_io_bitmap_check),
		.o_interrupt_return_op_intertask(o_interrupt_return_op_intertask),
		.o_index_step(o_index_step),
		.o_vm86_active(o_vm86_active),
		.o_mc(o_mc),
		.o_status_word(o_status_word),
		.o_paging_en(o_paging_en),
		.o_prot_en(o_prot_en),
		.o_sel(o_sel),
		.o_linear(o_linear),
		.o_limit_fault(o_limit_fault),
		.o_attr_fault(o_attr_fault)
	);
	// clock and hang guard
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles > 3000)
		begin
			num_errors++;
			complete_run();
		end
	end
	task complete_run;
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task cyc;
		@(negedge i_clk);
	endtask
	// one flags load, then idle
	task fw(input cfs_fwr_t k, input logic [1:0] c, input logic [31:0] d);
		cyc;
		i_fl_wr = k;
		i_cpl = c;
		i_fl_wdata = d;
		cyc;
		i_fl_wr = CFS_FW_NONE;
	endtask
	task mw(input cfs_mwr_t k, input logic [31:0] d);
		cyc;
		i_mc_wr = k;
		i_mc_wdata = d;
		cyc;
		i_mc_wr = CFS_MW_NONE;
	endtask
	task sl(input logic [2:0] s, input logic [15:0] v, input cfs_desc_t d);
		cyc;
		i_seg_ld = 1;
		i_seg_idx = s;
		i_seg_sel = v;
		i_seg_desc = d;
		cyc;
		i_seg_ld = 0;
	endtask
	// memory reference and its address checks
	task mr(input logic [2:0] s, input logic w, input logic [31:0] off, lin, input logic lf, af);
		cyc;
		i_mref = '{1'b1, s, w, 1'b0, off};
		#1;
		chk("linear", lin, o_linear);
		chk("limit fault", lf, o_limit_fault);
		chk("attr fault", af, o_attr_fault);
	endtask
	task alu(input cfs_size_t z, input logic sub, input logic [31:0] a, b, r, f);
		logic [31:0] m;
		m = z == CFS_SZ8 ? 32'h0000_00ff : z == CFS_SZ16 ? 32'h0000_ffff : 32'hffff_ffff;
		cyc;
		i_alu = '{1'b1, z, sub, a, b, 1'b0};
		#1;
		chk("result", r, o_alu_result & m);
		cyc;
		i_alu.valid = 0;
		chk("status flags", f, o_flags & 32'h0000_08d5);
	endtask
	task t_alu;
		alu(CFS_SZ8, 0, 32'h7f, 32'h1, 32'h80, 32'h890);
		alu(CFS_SZ16, 0, 32'hffff, 32'h1, 32'h0, 32'h55);
		alu(CFS_SZ32, 1, 32'h0, 32'h1, 32'hffff_ffff, 32'h95);
		// carry held when the datapath does not update it
		i_alu_upd_cf = 0;
		alu(CFS_SZ8, 0, 32'h1, 32'h1, 32'h2, 32'h1);
		i_alu_upd_cf = 1;
	endtask
	// pop at level three, resume, step and direction
	task t_pop_flags_op;
		fw(CFS_FW_POP_FLAGS_OP, 3, 32'hffff_ffff);
		chk("flags", 32'h0001_4dd7, o_flags);
		i_debug_hit = 1;
		#1;
		chk("debug fault", 0, o_debug_fault);
		chk("index step", 32'hffff_ffff, 32'(o_index_step));
		cyc;
		i_insn_done = 1;
		cyc;
		i_insn_done = 0;
		#1;
		chk("resume", 0, o_flags[FL_RESUME]);
		chk("debug fault", 1, o_debug_fault);
		cyc;
		i_insn_done = 1;
		#1;
		chk("step trap", 1, o_step_trap);
		cyc;
		i_insn_done = 0;
		i_debug_hit = 0;
		fw(CFS_FW_POP_FLAGS_OP, 0, 32'h0);
		chk("flags", FL_FIXED_ONE, o_flags);
	endtask
	task t_prot;
		mw(CFS_MW_FULL, 32'h8000_0001);
		chk("paging", 1, o_paging_en);
		sl(2, 16'h0018, '{32'h1000_0000, 32'h0000_0fff, 8'h93});
		mr(2, 0, 32'h20, 32'h1000_0020, 0, 0);
		mr(2, 0, 32'h1000, 32'h1000_1000, 1, 0);
		sl(2, 16'h0008, '{32'h0, 32'hffff_ffff, 8'h91});
		mr(2, 1, 32'h0, 32'h0, 0, 1);
	endtask
	// virtual mode entered by a level zero return
	task t_vm;
		fw(CFS_FW_INTERRUPT_RETURN_OP, 0, 32'h0002_4202);
		chk("flags", 32'h0002_4202, o_flags);
		i_task_vm86 = 1;
		i_maskable_irq_pin = 1;
		i_priv_insn = 1;
		#1;
		chk("vm active", 1, o_vm86_active);
		chk("gp fault", 1, o_gp_fault);
		chk("irq", 1, o_irq_take);
		chk("push vm", 0, o_flags_push[FL_VMODE]);
		chk("saved vm", 1, o_flags_saved[FL_VMODE]);
		fw(CFS_FW_POP_FLAGS_OP, 3, 32'h0);
		chk("flags", 32'h0002_0202, o_flags);
		sl(1, 16'h0100, '{32'h5555_0000, 32'h0, 8'h0});
		mr(1, 1, 32'h10, 32'h0000_1010, 0, 0);
		fw(CFS_FW_TASK, 0, FL_FIXED_ONE);
		i_priv_insn = 0;
		#1;
		chk("irq", 0, o_irq_take);
	endtask
	// return kind, saved image, faulted resume, io check, fetch check, direct load
	task t_sys;
		fw(CFS_FW_INTERRUPT_RETURN_OP, 0, 32'h0001_7002);
		chk("flags", 32'h0001_7002, o_flags);
		chk("intertask", 1, o_interrupt_return_op_intertask);
		chk("saved vm", 32'h0003_7002, o_flags_saved);
		i_task_vm86 = 0;
		#1;
		chk("saved vm", 32'h0001_7002, o_flags_saved);
		cyc;
		i_insn_done = 1;
		i_insn_fault = 1;
		i_io_insn = 1;
		i_cpl = 3;
		#1;
		chk("io check", 0, o_io_bitmap_check);
		cyc;
		i_insn_done = 0;
		i_insn_fault = 0;
		chk("resume", 1, o_flags[FL_RESUME]);
		fw(CFS_FW_POP_FLAGS_OP, 0, 32'h0000_1000);
		chk("flags", 32'h0000_1002, o_flags);
		chk("intertask", 0, o_interrupt_return_op_intertask);
		i_cpl = 3;
		#1;
		chk("io check", 1, o_io_bitmap_check);
		cyc;
		i_cpl = 1;
		#1;
		chk("io check", 0, o_io_bitmap_check);
		sl(4, 16'h0020, '{32'h0004_0000, 32'h0000_ffff, 8'h9a});
		mr(4, 1, 32'h10, 32'h0004_0010, 0, 1);
		cyc;
		i_io_insn = 0;
		i_mref = '{1'b1, 3'h4, 1'b0, 1'b1, 32'h10};
		#1;
		chk("attr fault", 0, o_attr_fault);
		chk("selector", 16'h0020, o_sel[4]);
		cyc;
		i_mref.seg = 3'h2;
		#1;
		chk("attr fault", 1, o_attr_fault);
		fw(CFS_FW_DIRECT, 0, 32'hffff_ffff);
		chk("flags", 32'h0001_7fd7, o_flags);
	endtask
	task t_mc;
		mw(CFS_MW_LOAD_STATUS_WORD_OP, 32'h0);
		chk("control", 32'h8000_0001, o_mc);
		chk("status word", 32'h1, o_status_word);
		mw(CFS_MW_FULL, 32'h0);
		chk("control", 32'h0, o_mc);
		sl(3, 16'h1234, '{32'hffff_ffff, 32'h0, 8'h0});
		mr(3, 0, 32'h1_0000, 32'h0002_2340, 1, 0);
	endtask
	// main sequence
	initial
	begin
		repeat (12) cyc;
		i_rst_b = 1;
		repeat (3) cyc;
		chk("flags reset", FL_RESET, o_flags);
		chk("control reset", MC_RESET, o_mc);
		t_alu;
		t_pop_flags_op;
		t_prot;
		t_vm;
		t_sys;
		t_mc;
		complete_run();
	end
endmodule // cfs_core_tb
`default_nettype wire
